// file: rrc_top.sv
/*
 Remote register command block: instruction slots, replies, monitors,
 fault history and controller set points on the cyclic register words.
 Assumes all inputs come from link logic on core_clk, so none is synchronised.
*/
// Contract
// RULE_01: On request run the main slot, then extension slots one to five in order.
// RULE_02: Raise the done flag once every enabled slot has executed.
// RULE_03: Skip an extension slot holding ffff; always run the main slot.
// RULE_04: Upper byte of an instruction is expansion setting, the rest the code.
// RULE_05: A parameter read uses a code equal to the parameter number.
// RULE_06: Master loads instruction and write data before raising the request.
// RULE_07: Master loads zero write data when an instruction needs none.
// RULE_08: With monitor request, first monitor word shows low select byte quantity.
// RULE_09: Upper select byte zero gives output frequency, else its quantity on request.
// RULE_10: Reply format zero: main reply is a full 16-bit code, zero normal.
// RULE_11: Reply format nonzero: low byte holds the frequency set reply.
// RULE_12: Reply format nonzero: high byte holds the main instruction reply.
// RULE_13: On a normal reply place the result in that slot's read data word.
// RULE_14: With monitor request, monitor words three to six follow select words four to seven.
// RULE_15: Fault code word: low byte the code, high byte echoes the index.
// RULE_16: Report fault frequency, current, voltage and powered time in four words.
// RULE_17: Each extension slot gets its own reply, zero normal, nonzero fault.
// RULE_18: Set points accepted only for control action 50, 51, 60 or 61.
// RULE_19: Replies: 0 normal, 1 write mode, 2 unknown code, 3 out of range.
// RULE_20: Master holds request until done; done clears once request is low.
`include "rrc_map.svh"

module rrc_top
  import rrc_pkg::*;
#(
  parameter int MON_N = 16,
  parameter int FAULT_N = `RRC_FAULT_DEPTH
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic instruction_execute_request,
  input wire logic monitor_request,
  input wire logic frequency_set_request_a,
  input wire logic frequency_set_request_b,
  input wire rrc_word_type frequency_set_word,
  input wire rrc_word_type monitor_select_code,
  input wire rrc_word_type [3:0] monitor_select_words,
  input wire rrc_word_type main_instruction_slot,
  input wire rrc_word_type main_write_data,
  input wire rrc_word_type fault_index_select,
  input wire rrc_word_type pid_set_point_word,
  input wire rrc_word_type pid_measured_word,
  input wire rrc_word_type [`RRC_EXT_SLOTS-1:0] extension_instruction_slots,
  input wire rrc_word_type [`RRC_EXT_SLOTS-1:0] extension_write_data_slots,
  input wire logic inverter_running,
  input wire rrc_word_type output_frequency,
  input wire rrc_word_type output_current,
  input wire rrc_word_type output_voltage,
  input wire rrc_word_type [MON_N-1:0] monitor_sources,
  input wire logic [FAULT_N-1:0][7:0] fault_codes,
  input wire rrc_word_type [FAULT_N-1:0] fault_frequencies,
  input wire rrc_word_type [FAULT_N-1:0] fault_currents,
  input wire rrc_word_type [FAULT_N-1:0] fault_voltages,
  input wire rrc_word_type [FAULT_N-1:0] fault_powered_times,
  output logic instruction_done_flag,
  output rrc_word_type first_monitor_value,
  output rrc_word_type second_monitor_value,
  output rrc_word_type main_reply_code,
  output rrc_word_type main_read_data,
  output rrc_word_type [3:0] further_monitor_values,
  output rrc_word_type fault_history_code,
  output rrc_word_type fault_history_frequency,
  output rrc_word_type fault_history_current,
  output rrc_word_type fault_history_voltage,
  output rrc_word_type fault_history_powered_time,
  output rrc_word_type [`RRC_EXT_SLOTS-1:0] extension_reply_codes,
  output rrc_word_type [`RRC_EXT_SLOTS-1:0] extension_read_data,
  output rrc_word_type reply_format_parameter,
  output rrc_word_type control_action_parameter,
  output rrc_word_type operation_mode,
  output rrc_word_type frequency_command,
  output rrc_word_type pid_set_point,
  output rrc_word_type pid_measured_value
);

  ////////////////////////////////////////////////////////////////////////////
  // State and helpers

  rrc_state_type s_r;
  rrc_state_type s_nxt;

  rrc_word_type cur_code;
  rrc_word_type cur_wdata;
  rrc_word_type ex_reply;
  rrc_word_type ex_rdata;
  logic ex_wr_mode;
  logic ex_wr_fmt;
  logic ex_wr_ctrl;
  logic ex_wr_example;
  logic [2:0] ext_idx;
  logic slot_skip;
  logic start;
  logic freq_edge;
  logic ctrl_ok;
  logic [7:0] fault_idx;
  logic [7:0] mon_sel [`RRC_MON_WORDS];
  rrc_word_type mon_val [`RRC_MON_WORDS];

  assign ext_idx = s_r.slot - 3'h1;
  // Main slot is slot 0; extension slots follow in ascending order
  assign cur_code = (s_r.slot == 3'h0) ? main_instruction_slot : extension_instruction_slots[ext_idx]; // RULE_01
  // Write data is trusted as loaded before the request rose
  assign cur_wdata = (s_r.slot == 3'h0) ? main_write_data : extension_write_data_slots[ext_idx]; // RULE_06
  assign slot_skip = s_r.slot != 3'h0 && cur_code == `RRC_SKIP_CODE; // RULE_03
  // Level request, so a held request does not retrigger until dropped
  assign start = s_r.seq == SEQ_IDLE && instruction_execute_request && !s_r.done; // RULE_20
  assign freq_edge = (frequency_set_request_a && !s_r.fa_d) || (frequency_set_request_b && !s_r.fb_d);
  assign ctrl_ok = s_r.ctrl_act == `RRC_CTRL_A || s_r.ctrl_act == `RRC_CTRL_B ||
                   s_r.ctrl_act == `RRC_CTRL_C || s_r.ctrl_act == `RRC_CTRL_D; // RULE_18
  assign fault_idx = fault_index_select[15:8];

  ////////////////////////////////////////////////////////////////////////////
  // Instruction executor and monitor selectors

  rrc_slot_exec u_exec (
    .code(cur_code),
    .wdata(cur_wdata),
    .inverter_running(inverter_running),
    .op_mode(s_r.op_mode),
    .reply_fmt(s_r.reply_fmt),
    .ctrl_act(s_r.ctrl_act),
    .example(s_r.example),
    .output_frequency(output_frequency),
    .output_current(output_current),
    .output_voltage(output_voltage),
    .reply(ex_reply),
    .rdata(ex_rdata),
    .wr_mode(ex_wr_mode),
    .wr_fmt(ex_wr_fmt),
    .wr_ctrl(ex_wr_ctrl),
    .wr_example(ex_wr_example)
  );

  assign mon_sel[0] = monitor_select_code[7:0]; // RULE_08
  assign mon_sel[1] = monitor_select_code[15:8]; // RULE_09

  genvar w;
  generate
    for (w = 0; w < `RRC_MON_WORDS; w++) begin : g_mon
      if (w >= 2) begin : g_sel
        assign mon_sel[w] = monitor_select_words[w-2][7:0]; // RULE_14
      end
      rrc_mon_mux #(.MON_N(MON_N)) u_mux (
        .sel(mon_sel[w]),
        .sources(monitor_sources),
        .value(mon_val[w])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    rrc_word_type fr;
    fr = `RRC_REPLY_OK;
    s_nxt = s_r;
    s_nxt.fa_d = frequency_set_request_a;
    s_nxt.fb_d = frequency_set_request_b;

    // Monitor words hold their last value while the request is off; word 1 follows output frequency while select byte 15:8 is zero
    if (monitor_request) begin
      s_nxt.mon[0] = mon_val[0]; // RULE_08
    end
    if (monitor_select_code[15:8] == 8'h00) begin
      s_nxt.mon[1] = output_frequency; // RULE_09
    end else if (monitor_request) begin
      s_nxt.mon[1] = mon_val[1]; // RULE_09
    end
    for (int i = 2; i < `RRC_MON_WORDS; i++) begin
      if (monitor_request) begin
        s_nxt.mon[i] = mon_val[i]; // RULE_14
      end
    end

    // Fault history; an index past the depth reads as zero data
    if (32'(fault_idx) < FAULT_N) begin
      s_nxt.fh_code = {fault_idx, fault_codes[fault_idx[2:0]]}; // RULE_15
      s_nxt.fh_freq = fault_frequencies[fault_idx[2:0]]; // RULE_16
      s_nxt.fh_curr = fault_currents[fault_idx[2:0]]; // RULE_16
      s_nxt.fh_volt = fault_voltages[fault_idx[2:0]]; // RULE_16
      s_nxt.fh_time = fault_powered_times[fault_idx[2:0]]; // RULE_16
    end else begin
      s_nxt.fh_code = {fault_idx, 8'h00}; // RULE_15
      s_nxt.fh_freq = 16'h0000;
      s_nxt.fh_curr = 16'h0000;
      s_nxt.fh_volt = 16'h0000;
      s_nxt.fh_time = 16'h0000;
    end

    // Frequency set reply shares the main reply word
    if (freq_edge) begin
      if (s_r.op_mode != `RRC_OP_MODE_NET) fr = `RRC_REPLY_MODE_ERR; // RULE_19
      else if (frequency_set_word > `RRC_FREQ_MAX) fr = `RRC_REPLY_RANGE_ERR;
      else s_nxt.set_freq = frequency_set_word;
      if (s_r.reply_fmt == 16'h0000) s_nxt.main_reply = fr; // RULE_10
      else s_nxt.main_reply[7:0] = fr[7:0]; // RULE_11
    end

    // Set points rejected, old value kept, outside the allowed actions
    if (ctrl_ok && pid_set_point_word <= `RRC_PID_MAX) begin
      s_nxt.pid_sp = pid_set_point_word; // RULE_18
    end
    if (ctrl_ok && pid_measured_word <= `RRC_PID_MAX) begin
      s_nxt.pid_mv = pid_measured_word; // RULE_18
    end

    case (s_r.seq)
      SEQ_IDLE: begin
        if (start) begin
          s_nxt.seq = SEQ_RUN;
          s_nxt.slot = 3'h0; // RULE_01
        end
      end
      SEQ_RUN: begin
        if (!slot_skip) begin // RULE_03
          if (s_r.slot == 3'h0) begin
            if (s_r.reply_fmt == 16'h0000) s_nxt.main_reply = ex_reply; // RULE_10
            else s_nxt.main_reply[15:8] = ex_reply[7:0]; // RULE_12
            if (ex_reply == `RRC_REPLY_OK) s_nxt.main_rdata = ex_rdata; // RULE_13
          end else begin
            s_nxt.ext_reply[ext_idx] = ex_reply; // RULE_17
            if (ex_reply == `RRC_REPLY_OK) s_nxt.ext_rdata[ext_idx] = ex_rdata; // RULE_13
          end
          if (ex_wr_mode) s_nxt.op_mode = cur_wdata;
          if (ex_wr_fmt) s_nxt.reply_fmt = cur_wdata;
          if (ex_wr_ctrl) s_nxt.ctrl_act = cur_wdata;
          if (ex_wr_example) s_nxt.example = cur_wdata;
        end
        if (s_r.slot == `RRC_LAST_SLOT) begin
          s_nxt.seq = SEQ_DONE;
          s_nxt.done = 1'b1; // RULE_02
        end else begin
          s_nxt.slot = s_r.slot + 3'h1; // RULE_01
        end
      end
      SEQ_DONE: begin
        if (!instruction_execute_request) begin
          s_nxt.seq = SEQ_IDLE;
          s_nxt.done = 1'b0; // RULE_20
        end
      end
      default: begin
        s_nxt.seq = SEQ_IDLE;
        s_nxt.done = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_r <= '0;
      s_r.seq <= SEQ_IDLE;
      s_r.reply_fmt <= `RRC_RST_REPLY_FMT;
      s_r.ctrl_act <= `RRC_RST_CTRL_ACT;
      s_r.example <= `RRC_RST_EXAMPLE;
      s_r.op_mode <= `RRC_RST_OP_MODE;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register

  assign instruction_done_flag = s_r.done;
  assign first_monitor_value = s_r.mon[0];
  assign second_monitor_value = s_r.mon[1];
  assign further_monitor_values = s_r.mon[5:2];
  assign main_reply_code = s_r.main_reply;
  assign main_read_data = s_r.main_rdata;
  assign fault_history_code = s_r.fh_code;
  assign fault_history_frequency = s_r.fh_freq;
  assign fault_history_current = s_r.fh_curr;
  assign fault_history_voltage = s_r.fh_volt;
  assign fault_history_powered_time = s_r.fh_time;
  assign extension_reply_codes = s_r.ext_reply;
  assign extension_read_data = s_r.ext_rdata;
  assign reply_format_parameter = s_r.reply_fmt;
  assign control_action_parameter = s_r.ctrl_act;
  assign operation_mode = s_r.op_mode;
  assign frequency_command = s_r.set_freq;
  assign pid_set_point = s_r.pid_sp;
  assign pid_measured_value = s_r.pid_mv;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_run_length: assert property (start |=> ##6 s_r.done) // RULE_02
    else $error("done flag not raised seven cycles after start");

  a_main_first: assert property (start |=> s_r.seq == SEQ_RUN && s_r.slot == 3'h0) // RULE_01
    else $error("sequence did not begin at the main slot");

  a_slot_order: assert property (s_r.seq == SEQ_RUN && s_r.slot != `RRC_LAST_SLOT
    |=> s_r.seq == SEQ_RUN && s_r.slot == $past(s_r.slot) + 3'h1) // RULE_01
    else $error("slots not executed in ascending order");

  a_done_source: assert property ($rose(s_r.done) |-> $past(s_r.slot) == `RRC_LAST_SLOT) // RULE_02
    else $error("done flag raised before the last slot");

  a_done_clear: assert property (s_r.done && !instruction_execute_request |=> !s_r.done) // RULE_20
    else $error("done flag not cleared after request dropped");

  a_skip_keeps: assert property (s_r.seq == SEQ_RUN && slot_skip |=> $stable(s_r.ext_reply)) // RULE_03
    else $error("skipped extension slot changed a reply");

  a_ext_reply: assert property (s_r.seq == SEQ_RUN && s_r.slot != 3'h0 && !slot_skip
    |=> s_r.ext_reply[$past(ext_idx)] == $past(ex_reply)) // RULE_17
    else $error("extension reply not stored in its own word");

  a_fmt_upper: assert property (s_r.seq == SEQ_RUN && s_r.slot == 3'h0 && s_r.reply_fmt != 16'h0000
    |=> s_r.main_reply[15:8] == $past(ex_reply[7:0])) // RULE_12
    else $error("main instruction reply not in upper byte");

  a_mon_freq: assert property (!reset && monitor_select_code[15:8] == 8'h00
    |=> second_monitor_value == $past(output_frequency)) // RULE_09
    else $error("second monitor word not output frequency");

  a_fault_echo: assert property (!reset |=> fault_history_code[15:8] == $past(fault_idx)) // RULE_15
    else $error("fault index not echoed");

  a_pid_reject: assert property (!ctrl_ok |=> $stable(s_r.pid_sp) && $stable(s_r.pid_mv)) // RULE_18
    else $error("set point changed under a disallowed control action");

endmodule

// file: rrc_map.svh
/*
 Remote register command block: offsets, codes, limits and counts.
 Assumes inclusion by the package and the design modules only.
*/
`ifndef RRC_MAP_SVH
`define RRC_MAP_SVH

// Slot, monitor word and fault history counts
`define RRC_SLOTS 6
`define RRC_EXT_SLOTS 5
`define RRC_LAST_SLOT 3'h5
`define RRC_MON_WORDS 6
`define RRC_FAULT_DEPTH 8

// Instruction word fields
`define RRC_SKIP_CODE 16'hffff
`define RRC_EXP_MSB 15
`define RRC_EXP_LSB 8
`define RRC_WRITE_BIT 7

// Reply codes
`define RRC_REPLY_OK 16'h0000
`define RRC_REPLY_MODE_ERR 16'h0001
`define RRC_REPLY_SEL_ERR 16'h0002
`define RRC_REPLY_RANGE_ERR 16'h0003

// Fixed instruction codes, write flag cleared
`define RRC_CODE_OP_MODE 16'h007b
`define RRC_CODE_OUT_FREQ 16'h006f
`define RRC_CODE_OUT_CURR 16'h0070
`define RRC_CODE_OUT_VOLT 16'h0071

// Parameter numbers as the low 15 bits of {expansion byte, 1'b0, code[6:0]}
`define RRC_PNUM_REPLY_FMT 15'h0544
`define RRC_PNUM_CTRL_ACT 15'h0128
`define RRC_PNUM_EXAMPLE 15'h0300

// Reset values and ranges
`define RRC_RST_REPLY_FMT 16'h0000
`define RRC_RST_CTRL_ACT 16'h0000
`define RRC_RST_EXAMPLE 16'h0000
`define RRC_RST_OP_MODE 16'h0000
`define RRC_OP_MODE_NET 16'h0000
`define RRC_OP_MODE_MAX 16'h0002
`define RRC_REPLY_FMT_MAX 16'h0001
`define RRC_CTRL_ACT_MAX 16'h006e
`define RRC_EXAMPLE_MAX 16'h00ff
`define RRC_FREQ_MAX 16'h9c40
`define RRC_PID_MAX 16'h2710

// Control actions that enable the controller set points
`define RRC_CTRL_A 16'h0032
`define RRC_CTRL_B 16'h0033
`define RRC_CTRL_C 16'h003c
`define RRC_CTRL_D 16'h003d

`endif

// file: rrc_pkg.sv
/*
 Types of the remote register command block.
 Assumes rrc_map.svh is on the include path.
*/
`include "rrc_map.svh"

package rrc_pkg;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_DONE} rrc_seq_type;

  typedef logic [15:0] rrc_word_type;

  typedef struct packed {
    rrc_seq_type seq;
    logic [2:0] slot;
    logic done;
    logic fa_d;
    logic fb_d;
    rrc_word_type main_reply;
    rrc_word_type main_rdata;
    rrc_word_type [`RRC_EXT_SLOTS-1:0] ext_reply;
    rrc_word_type [`RRC_EXT_SLOTS-1:0] ext_rdata;
    rrc_word_type [`RRC_MON_WORDS-1:0] mon;
    rrc_word_type fh_code;
    rrc_word_type fh_freq;
    rrc_word_type fh_curr;
    rrc_word_type fh_volt;
    rrc_word_type fh_time;
    rrc_word_type reply_fmt;
    rrc_word_type ctrl_act;
    rrc_word_type example;
    rrc_word_type op_mode;
    rrc_word_type set_freq;
    rrc_word_type pid_sp;
    rrc_word_type pid_mv;
  } rrc_state_type;

endpackage

// file: rrc_mon_mux.sv
/*
 One monitor word selector: picks a quantity by its monitor code.
 Assumes the sources are same-clock words; code 0 or out of range reads 0.
*/
`include "rrc_map.svh"

module rrc_mon_mux
  import rrc_pkg::*;
#(
  parameter int MON_N = 16
) (
  input wire logic [7:0] sel,
  input wire rrc_word_type [MON_N-1:0] sources,
  output rrc_word_type value
);

  always_comb begin
    value = 16'h0000;
    if (sel != 8'h00 && 32'(sel) < MON_N) begin
      value = sources[sel];
    end
  end

endmodule

// file: rrc_slot_exec.sv
/*
 Executes one instruction word: decode, range check, reply and read data.
 Assumes the caller applies the write strobes only on the executing cycle.
*/
`include "rrc_map.svh"

module rrc_slot_exec
  import rrc_pkg::*;
(
  input wire rrc_word_type code,
  input wire rrc_word_type wdata,
  input wire logic inverter_running,
  input wire rrc_word_type op_mode,
  input wire rrc_word_type reply_fmt,
  input wire rrc_word_type ctrl_act,
  input wire rrc_word_type example,
  input wire rrc_word_type output_frequency,
  input wire rrc_word_type output_current,
  input wire rrc_word_type output_voltage,
  output rrc_word_type reply,
  output rrc_word_type rdata,
  output logic wr_mode,
  output logic wr_fmt,
  output logic wr_ctrl,
  output logic wr_example
);

  logic is_write;
  logic [14:0] pnum;
  rrc_word_type base;
  logic may_write;

  // Upper byte is the expansion setting, bit 7 the write flag, bits 6 to 0 the code proper
  assign is_write = code[`RRC_WRITE_BIT]; // RULE_04
  assign pnum = {code[`RRC_EXP_MSB:`RRC_EXP_LSB], code[6:0]}; // RULE_04 RULE_05
  assign base = {pnum[14:7], 1'b0, pnum[6:0]};
  assign may_write = !inverter_running && op_mode == `RRC_OP_MODE_NET;

  always_comb begin
    reply = `RRC_REPLY_OK;
    rdata = 16'h0000;
    wr_mode = 1'b0;
    wr_fmt = 1'b0;
    wr_ctrl = 1'b0;
    wr_example = 1'b0;
    if (!is_write) begin
      case (base)
        `RRC_CODE_OP_MODE: rdata = op_mode;
        `RRC_CODE_OUT_FREQ: rdata = output_frequency;
        `RRC_CODE_OUT_CURR: rdata = output_current;
        `RRC_CODE_OUT_VOLT: rdata = output_voltage;
        {1'b0, `RRC_PNUM_REPLY_FMT}: rdata = reply_fmt; // RULE_05
        {1'b0, `RRC_PNUM_CTRL_ACT}: rdata = ctrl_act; // RULE_05
        {1'b0, `RRC_PNUM_EXAMPLE}: rdata = example; // RULE_05
        default: reply = `RRC_REPLY_SEL_ERR; // RULE_19
      endcase
    end else begin
      // Mode change only needs a stop; parameters need network mode too
      case (base)
        `RRC_CODE_OP_MODE: begin
          if (inverter_running) reply = `RRC_REPLY_MODE_ERR; // RULE_19
          else if (wdata > `RRC_OP_MODE_MAX) reply = `RRC_REPLY_RANGE_ERR;
          else wr_mode = 1'b1;
        end
        {1'b0, `RRC_PNUM_REPLY_FMT}: begin
          if (!may_write) reply = `RRC_REPLY_MODE_ERR; // RULE_19
          else if (wdata > `RRC_REPLY_FMT_MAX) reply = `RRC_REPLY_RANGE_ERR;
          else wr_fmt = 1'b1;
        end
        {1'b0, `RRC_PNUM_CTRL_ACT}: begin
          if (!may_write) reply = `RRC_REPLY_MODE_ERR;
          else if (wdata > `RRC_CTRL_ACT_MAX) reply = `RRC_REPLY_RANGE_ERR; // RULE_19
          else wr_ctrl = 1'b1;
        end
        {1'b0, `RRC_PNUM_EXAMPLE}: begin
          if (!may_write) reply = `RRC_REPLY_MODE_ERR;
          else if (wdata > `RRC_EXAMPLE_MAX) reply = `RRC_REPLY_RANGE_ERR;
          else wr_example = 1'b1;
        end
        default: reply = `RRC_REPLY_SEL_ERR; // RULE_19
      endcase
    end
  end

endmodule

// file: rrc_master.sv
/*
 Fieldbus master stand-in for the execute handshake.
 Assumes the bench loads the slot words before it pulses start.
*/
module rrc_master (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic done,
  output logic req
);
  timeunit 1ns;
  timeprecision 1ns;
  // Words are already loaded when start arrives
  always_ff @(posedge core_clk) begin
    if (reset) begin
      req <= 1'b0;
    end else if (start && !done) begin
      req <= 1'b1;
    end else if (done) begin
      req <= 1'b0;
    end
  end
endmodule

// file: test_remote_register_command_exec.sv
/*
 Self-checking bench for the remote register command block.
 Assumes rrc_map.svh, rrc_pkg and rrc_master are compiled first.
*/
module test_remote_register_command_exec
  import rrc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, reset, req, start, done, mreq, fa, fb, run;
  rrc_word_type fword, msel, mains, mainw, fidx, psw, ofreq, ocurr, ovolt;
  rrc_word_type mon1, mon2, mrep, mrd, fhc, fhf, fhi, fhv, fht, fmt_o, ctl_o, opm_o, fcmd, psp, pmv;
  rrc_word_type fexp = '0, pexp = '0;
  rrc_word_type [3:0] msw, mfur;
  rrc_word_type [4:0] exs, exw, erep, erd;
  rrc_word_type [15:0] msrc;
  logic [7:0][7:0] fcode;
  rrc_word_type [7:0] ff, fc, fv, ft;
  rrc_word_type prev [5] = '{default: '0};
  int miscompares, checks_done, store [4];
  int lim [4] = '{2, 1, 'h6e, 'hff};
  ////////////////////////////////////////
  rrc_top dut (
    .core_clk(core_clk), .reset(reset), .instruction_execute_request(req), .monitor_request(mreq),
    .frequency_set_request_a(fa), .frequency_set_request_b(fb), .frequency_set_word(fword),
    .monitor_select_code(msel), .monitor_select_words(msw), .main_instruction_slot(mains),
    .main_write_data(mainw), .fault_index_select(fidx), .pid_set_point_word(psw), .pid_measured_word(psw),
    .extension_instruction_slots(exs), .extension_write_data_slots(exw), .inverter_running(run),
    .output_frequency(ofreq), .output_current(ocurr), .output_voltage(ovolt), .monitor_sources(msrc),
    .fault_codes(fcode), .fault_frequencies(ff), .fault_currents(fc), .fault_voltages(fv),
    .fault_powered_times(ft), .instruction_done_flag(done), .first_monitor_value(mon1),
    .second_monitor_value(mon2), .main_reply_code(mrep), .main_read_data(mrd), .further_monitor_values(mfur),
    .fault_history_code(fhc), .fault_history_frequency(fhf), .fault_history_current(fhi),
    .fault_history_voltage(fhv), .fault_history_powered_time(fht), .extension_reply_codes(erep),
    .extension_read_data(erd), .reply_format_parameter(fmt_o), .control_action_parameter(ctl_o),
    .operation_mode(opm_o), .frequency_command(fcmd), .pid_set_point(psp), .pid_measured_value(pmv)
  );
  rrc_master master (.core_clk(core_clk), .reset(reset), .start(start), .done(done), .req(req));
  ////////////////////////////////////////
  task automatic check(input rrc_word_type seen, input rrc_word_type exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Parameter store as integers; index 0 op mode, 1 format, 2 control action, 3 example
  function automatic rrc_word_type slot_model(input rrc_word_type c, input rrc_word_type w, output int rd);
    int k;
    k = -1;
    rd = -1;
    case ({c[15:8], 1'b0, c[6:0]})
      'h6f: rd = ofreq;
      'h70: rd = ocurr;
      'h71: rd = ovolt;
      'h7b: k = 0;
      'h544: k = 1;
      'h128: k = 2;
      'h300: k = 3;
      default: return 16'h0002;
    endcase
    if (c[7] && k < 0) return 16'h0002;
    if (k >= 0 && !c[7]) rd = store[k];
    if (c[7] && (run || (k != 0 && store[0] != 0))) return 16'h0001;
    if (k >= 0 && c[7] && w > lim[k]) return 16'h0003;
    if (k >= 0 && c[7]) store[k] = w;
    return 16'h0000;
  endfunction
  function automatic rrc_word_type mon_val(input logic [7:0] code);
    return (code == 0 || code > 15) ? 16'h0000 : msrc[code[3:0]];
  endfunction
  task automatic exec(input rrc_word_type c [6], input rrc_word_type w [6]);
    int rd, n, f;
    rrc_word_type r;
    f = store[1];
    @(posedge core_clk);
    mains <= c[0];
    mainw <= w[0];
    exs <= {c[5], c[4], c[3], c[2], c[1]};
    exw <= {w[5], w[4], w[3], w[2], w[1]};
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    for (n = 0; n < 30 && done !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    check(n[15:0] < 30, 16'h0001);
    for (int k = 0; k < 6; k++) begin
      r = slot_model(c[k], w[k], rd);
      if (k == 0 && f == 0) check(mrep, r);
      if (k == 0 && f != 0) check({8'h00, mrep[15:8]}, {8'h00, r[7:0]});
      if (k == 0 && rd >= 0) check(mrd, rd[15:0]);
      if (k > 0 && c[k] == 16'hffff) r = prev[k-1];
      if (k > 0) check(erep[k-1], r);
      if (k > 0 && c[k] != 16'hffff && rd >= 0) check(erd[k-1], rd[15:0]);
      if (k > 0) prev[k-1] = r;
    end
    check(opm_o, store[0]);
    check(fmt_o, store[1]);
    check(ctl_o, store[2]);
    for (n = 0; n < 5 && done !== 1'b0; n++) begin
      @(posedge core_clk);
      #1;
    end
    check({15'h0, done}, 16'h0000);
  endtask
  task automatic fset(input logic b, input rrc_word_type v);
    int r;
    r = store[0] != 0 ? 1 : v > 16'h9c40 ? 3 : 0;
    @(posedge core_clk);
    fword <= v;
    fa <= !b;
    fb <= b;
    repeat (2) @(posedge core_clk);
    #1;
    if (r == 0) fexp = v;
    check(fcmd, fexp);
    check(store[1] != 0 ? {8'h00, mrep[7:0]} : mrep, r[15:0]);
    @(posedge core_clk);
    fa <= 1'b0;
    fb <= 1'b0;
  endtask
  task automatic pid(input rrc_word_type v);
    @(posedge core_clk);
    psw <= v;
    repeat (2) @(posedge core_clk);
    #1;
    if (v <= 16'h2710 && store[2] inside {'h32, 'h33, 'h3c, 'h3d}) pexp = v;
    check(psp, pexp);
    check(pmv, pexp);
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Whole run is under two hundred cycles; this leaves wide margin
  initial begin
    #200us;
    miscompares++;
    print_verdict();
  end
  initial begin
    int s, i;
    {reset, start, mreq, fa, fb, run} = 6'h20;
    {fword, msel, mains, mainw, fidx, psw, msw, exs, exw} = '0;
    s = $urandom(32'h8cbefba0);
    ofreq = 16'($urandom);
    ocurr = 16'($urandom);
    ovolt = 16'($urandom);
    for (int k = 0; k < 16; k++) begin
      msrc[k] = 16'($urandom);
    end
    for (int k = 0; k < 8; k++) begin
      fcode[k] = 8'($urandom);
      {ff[k], fc[k]} = $urandom;
      {fv[k], ft[k]} = $urandom;
    end
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    #1;
    check(mrep, 16'h0000);
    pid(16'h0100);
    exec('{'h006f, 'h0070, 'hffff, 'h0099, 'h01a8, 'h0128}, '{0, 0, 0, 0, 'h0032, 0});
    pid(16'h2710);
    pid(16'h2711);
    fset(1'b0, 16'h9c40);
    fset(1'b1, 16'h9c41);
    exec('{'h0071, 'h0380, 'h0300, 'h01a8, 'h00fb, 'h05c4}, '{0, 'h0100, 0, 'h006f, 3, 1});
    @(posedge core_clk);
    run <= 1'b1;
    exec('{'h007b, 'hffff, 'h0380, 'h0544, 'h00fb, 'h0071}, '{0, 0, 'h0012, 0, 1, 0});
    fset(1'b0, 16'h1234);
    repeat (32) begin
      s = $urandom;
      @(posedge core_clk);
      mreq <= s[0];
      msel <= {s[1] ? {3'h0, s[13:9]} : 8'h00, 3'h0, s[8:4]};
      msw <= {12'h0, s[27:24], 12'h0, s[23:20], 12'h0, s[19:16], 11'h0, s[15:14], 3'h0};
      fidx <= {4'h0, s[31:28], 8'h00};
      @(posedge core_clk);
      #1;
      i = fidx[15:8];
      if (s[0]) check(mon1, mon_val(msel[7:0]));
      if (msel[15:8] == 0) check(mon2, ofreq);
      else if (s[0]) check(mon2, mon_val(msel[15:8]));
      for (int k = 0; k < 4; k++) begin
        if (s[0]) check(mfur[k], mon_val(msw[k][7:0]));
      end
      check(fhc, {fidx[15:8], i < 8 ? fcode[i[2:0]] : 8'h00});
      check(fhf, i < 8 ? ff[i[2:0]] : 16'h0000);
      check(fhi, i < 8 ? fc[i[2:0]] : 16'h0000);
      check(fhv, i < 8 ? fv[i[2:0]] : 16'h0000);
      check(fht, i < 8 ? ft[i[2:0]] : 16'h0000);
    end
    print_verdict();
  end
endmodule
